// >>> rtl/sld_pkg.sv
package sld_pkg;
    // Per-channel load result codes
    localparam logic [1:0] LOAD_NORMAL = 2'h0;
    localparam logic [1:0] LOAD_LINE = 2'h1;
    localparam logic [1:0] LOAD_OPEN = 2'h2;
    localparam logic [1:0] LOAD_INVALID = 2'h3;
    localparam int NUM_CH = 4;
    localparam int CLK_HZ = 40000000;
    localparam int OFFSET_STEP_MS = 15;
    localparam int OFFSET_STEP_CYC = OFFSET_STEP_MS * (CLK_HZ / 1000);
    localparam int SPIKE_CYC = 4;
    localparam int SLAM_CYC = 64;
    localparam int DIAG_WINDOW_CYC = 3 * OFFSET_STEP_CYC;
    localparam int STARTUP_CYC = OFFSET_STEP_CYC;
    typedef enum logic [2:0] {
        ST_OFF, ST_OFFSET_LOW, ST_OFFSET_HIGH, ST_OFFSET_DOWN, ST_EVAL, ST_AMP_START, ST_AMP_ON
    } sld_state_e;
endpackage

// >>> rtl/sld_startup_load_diagnostics.sv
// What this block does
// - I2C mode: shorts on fault pin, default on
// - I2C mode: overvoltage prewarn on fault pin, default off
// - Legacy: clip on fault pin, blocked at low supply
// - Classify each channel short, normal, open, booster
// - Booster detected allows line-driver low gain start
// - Impedance below threshold reports shorted load
// - Offset applied, raised 15 ms, lowered 15 ms later
// - Output over safety limit aborts diagnostics during offset low or high step
// - Short to battery channel reports invalid
// - Spike and door-slam filters on measurement
// - Cycle start: results invalid, busy flag set
// - Busy clears at completion, abort or power-on reset
// - Diag only: clear busy, load results, amp off
// - Toggling diag enable restarts diagnostics, from ST_OFF only
// - Both enabled: start amp, clear busy before unmute
// - Result codes 00 normal 01 line 10 open 11 invalid
// - Results readable only with result select zero
// - Short bits clear on host read with result select zero
// - I2C mode: fault pin low after reset until start bit
module sld_startup_load_diagnostics
    import sld_pkg::*;
#(
    parameter int OFFSET_CYC = OFFSET_STEP_CYC,
    parameter int WINDOW_CYC = DIAG_WINDOW_CYC,
    parameter int START_CYC = STARTUP_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic i2cMode,
    input wire logic ampStartBit,
    input wire logic diagEnableBit,
    input wire logic lowSupplyClipEnableBit,
    input wire logic resultSelectBit,
    input wire logic shortReportDisable,
    input wire logic ovPrewarnEnable,
    input wire logic resultRead,
    input wire logic [NUM_CH-1:0] acLoad,
    input wire logic [NUM_CH-1:0] measShort,
    input wire logic [NUM_CH-1:0] measOpen,
    input wire logic [NUM_CH-1:0] measBooster,
    input wire logic [NUM_CH-1:0] measShortBat,
    input wire logic [NUM_CH-1:0] measShortGnd,
    input wire logic outputOverLimit,
    input wire logic engineStart,
    input wire logic supplyLow,
    input wire logic ovPrewarn,
    input wire logic clipDetect,
    input wire logic otherFault,
    output logic diagBusyFlag,
    output logic ampOnStatusBit,
    output logic [NUM_CH-1:0] loadResultHighBit,
    output logic [NUM_CH-1:0] loadResultLowBit,
    output logic [NUM_CH-1:0] shortedLoad,
    output logic [NUM_CH-1:0] shortToBat,
    output logic [NUM_CH-1:0] shortToGnd,
    output logic lineDriverAllowed,
    output logic testOffsetOn,
    output logic testOffsetHigh,
    output logic muteRelease,
    output logic faultPinOe,
    output logic faultPinOut
);
    localparam int CW = $clog2(WINDOW_CYC + OFFSET_CYC + START_CYC + 1);
    localparam int FW = $clog2(SLAM_CYC + 1);

    initial begin
        if (OFFSET_CYC < 1 || WINDOW_CYC <= 2 * OFFSET_CYC || START_CYC < 1) begin
            $error("sld: bad timing parameters");
        end
    end

    sld_state_e state, next_state;
    logic [CW-1:0] cnt, next_cnt;
    logic [1:0] res [NUM_CH];
    logic [1:0] next_res [NUM_CH];
    logic [NUM_CH-1:0] next_shortedLoad, next_shortToBat, next_shortToGnd;
    logic busy, next_busy, started, next_started, booster, next_booster;
    logic diagEnPrev;
    logic [NUM_CH-1:0] spkShort, spkOpen, spkBoost;
    logic [FW-1:0] stable, next_stable;
    logic [3*NUM_CH-1:0] measPrev, measNow;

    assign measNow = {measShort, measOpen, measBooster};

    // Inputs must hold SLAM_CYC before a sample latches; spikes never reach it
    always_comb begin
        next_stable = stable;
        if (measNow != measPrev) begin
            next_stable = '0;
        end else if (stable != FW'(SLAM_CYC)) begin
            next_stable = stable + FW'(1);
        end
    end

    always_comb begin
        next_state = state;
        next_cnt = cnt + CW'(1);
        next_busy = busy;
        next_started = started;
        next_booster = booster;
        next_shortedLoad = shortedLoad;
        next_shortToBat = shortToBat;
        next_shortToGnd = shortToGnd;
        for (int i = 0; i < NUM_CH; i++) begin
            next_res[i] = res[i];
        end
        if (resultRead && !resultSelectBit) begin
            next_shortedLoad = '0;
            next_shortToBat = '0;
            next_shortToGnd = '0;
        end
        if (ampStartBit) begin
            next_started = 1'b1;
        end
        unique case (state)
            ST_OFF: begin
                next_cnt = '0;
                if (diagEnableBit && !diagEnPrev) begin
                    next_state = ST_OFFSET_LOW;
                    next_busy = 1'b1;
                    for (int i = 0; i < NUM_CH; i++) begin
                        next_res[i] = LOAD_INVALID;
                    end
                end else if (ampStartBit) begin
                    next_state = ST_AMP_START;
                end
            end
            ST_OFFSET_LOW: begin
                if (cnt == CW'(OFFSET_CYC - 1)) begin
                    next_state = ST_OFFSET_HIGH;
                    next_cnt = '0;
                end
            end
            ST_OFFSET_HIGH: begin
                if (cnt == CW'(OFFSET_CYC - 1)) begin
                    next_state = ST_OFFSET_DOWN;
                    next_cnt = '0;
                end
            end
            ST_OFFSET_DOWN: begin
                // Evaluate only once the filtered samples are fresh
                if (cnt >= CW'(WINDOW_CYC - 2 * OFFSET_CYC - 1) && stable >= FW'(SLAM_CYC)) begin
                    next_state = ST_EVAL;
                end
            end
            ST_EVAL: begin
                next_booster = 1'b0;
                for (int i = 0; i < NUM_CH; i++) begin
                    if (measShortBat[i] || engineStart || supplyLow) begin
                        next_res[i] = LOAD_INVALID;
                    end else if (spkBoost[i]) begin
                        next_res[i] = LOAD_LINE;
                        next_booster = 1'b1;
                    end else if (spkOpen[i]) begin
                        next_res[i] = LOAD_OPEN;
                    end else begin
                        next_res[i] = LOAD_NORMAL;
                    end
                end
                next_shortedLoad = shortedLoad | spkShort;
                next_shortToBat = shortToBat | measShortBat;
                next_shortToGnd = shortToGnd | measShortGnd;
                next_cnt = '0;
                if (ampStartBit) begin
                    next_state = ST_AMP_START;
                end else begin
                    next_busy = 1'b0;
                    next_state = ST_OFF;
                end
            end
            ST_AMP_START: begin
                if (cnt == CW'(START_CYC - 1)) begin
                    next_busy = 1'b0;
                    next_state = ST_AMP_ON;
                end
            end
            ST_AMP_ON: begin
                next_cnt = '0;
                if (!ampStartBit) begin
                    next_state = ST_OFF;
                end
            end
        endcase
        if (outputOverLimit && (state == ST_OFFSET_LOW || state == ST_OFFSET_HIGH)) begin
            next_state = ST_OFF;
            next_busy = 1'b0;
        end
        if (!ampStartBit && state == ST_AMP_START) begin
            next_state = ST_OFF;
            next_busy = 1'b0;
        end
        // Hardware set wins over a same-cycle read clear
        next_shortedLoad = next_shortedLoad | (shortedLoad & ~{NUM_CH{resultRead}});
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_OFF;
            cnt <= '0;
            busy <= 1'b0;
            started <= 1'b0;
            booster <= 1'b0;
            diagEnPrev <= 1'b0;
            stable <= '0;
            measPrev <= '0;
            shortedLoad <= '0;
            shortToBat <= '0;
            shortToGnd <= '0;
            spkShort <= '0;
            spkOpen <= '0;
            spkBoost <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                res[i] <= LOAD_INVALID;
            end
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            busy <= next_busy;
            started <= next_started;
            booster <= next_booster;
            diagEnPrev <= diagEnableBit;
            stable <= next_stable;
            measPrev <= measNow;
            if (stable >= FW'(SLAM_CYC)) begin
                spkShort <= measShort;
                spkOpen <= measOpen;
                spkBoost <= measBooster;
            end
            shortedLoad <= next_shortedLoad;
            shortToBat <= next_shortToBat;
            shortToGnd <= next_shortToGnd;
            for (int i = 0; i < NUM_CH; i++) begin
                res[i] <= next_res[i];
            end
        end
    end

    logic faultAny;
    always_comb begin
        if (i2cMode) begin
            faultAny = !started
                | (!shortReportDisable & (|(shortedLoad | shortToBat | shortToGnd)))
                | (ovPrewarnEnable & ovPrewarn)
                | (clipDetect & (!supplyLow | lowSupplyClipEnableBit))
                | otherFault;
        end else begin
            faultAny = (|(shortedLoad | shortToBat | shortToGnd))
                | (clipDetect & !supplyLow)
                | otherFault;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            diagBusyFlag <= 1'b0;
            ampOnStatusBit <= 1'b0;
            loadResultHighBit <= '1;
            loadResultLowBit <= '1;
            lineDriverAllowed <= 1'b0;
            testOffsetOn <= 1'b0;
            testOffsetHigh <= 1'b0;
            muteRelease <= 1'b0;
            faultPinOe <= 1'b1;
            faultPinOut <= 1'b0;
        end else begin
            diagBusyFlag <= busy;
            ampOnStatusBit <= (state == ST_AMP_START) || (state == ST_AMP_ON);
            for (int i = 0; i < NUM_CH; i++) begin
                loadResultHighBit[i] <= resultSelectBit ? 1'b0 : res[i][1];
                loadResultLowBit[i] <= resultSelectBit ? acLoad[i] : res[i][0];
            end
            lineDriverAllowed <= booster;
            testOffsetOn <= (state == ST_OFFSET_LOW) || (state == ST_OFFSET_HIGH)
                || (state == ST_OFFSET_DOWN);
            testOffsetHigh <= state == ST_OFFSET_HIGH;
            // Busy flag drops one cycle ahead of the unmute
            muteRelease <= (state == ST_AMP_ON) && !diagBusyFlag;
            faultPinOe <= faultAny;
            faultPinOut <= 1'b0;
        end
    end
endmodule // sld_startup_load_diagnostics

// >>> verif/sld_assertions.sv
module sld_assertions
    import sld_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ampStartBit,
    input wire logic diagEnableBit,
    input wire logic resultSelectBit,
    input wire logic resultRead,
    input wire logic outputOverLimit,
    input wire logic [NUM_CH-1:0] acLoad,
    input wire logic [NUM_CH-1:0] measShort,
    input wire logic diagBusyFlag,
    input wire logic ampOnStatusBit,
    input wire logic [NUM_CH-1:0] loadResultHighBit,
    input wire logic [NUM_CH-1:0] loadResultLowBit,
    input wire logic [NUM_CH-1:0] shortedLoad,
    input wire logic testOffsetOn,
    input wire logic testOffsetHigh,
    input wire logic muteRelease,
    input wire logic faultPinOe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire allInv = resultSelectBit || (&loadResultHighBit && &loadResultLowBit);
    sequence busyStart;
        ##2 diagBusyFlag && allInv;
    endsequence
    sequence offsetRaise;
        ##[8:12] $rose(testOffsetHigh) ##1 testOffsetHigh [*8];
    endsequence
    reset_state_a: assert property ($rose(resetn) |-> faultPinOe && !diagBusyFlag && allInv)
        else $error("bad state after reset");
    cycle_start_a: assert property ($rose(diagEnableBit) && !diagBusyFlag && !ampOnStatusBit |-> busyStart)
        else $error("cycle start wrong");
    // An abort cuts the offset steps short, so it is excluded here
    offset_steps_a: assert property (disable iff (!resetn || outputOverLimit) $rose(testOffsetOn) |-> offsetRaise)
        else $error("offset steps wrong");
    limit_abort_a: assert property (outputOverLimit && testOffsetOn |-> ##[1:4] !testOffsetOn && !diagBusyFlag)
        else $error("no abort on limit");
    diag_only_a: assert property ($fell(diagBusyFlag) && !ampStartBit |-> !ampOnStatusBit && !muteRelease)
        else $error("amp active after diag only");
    unmute_order_a: assert property ($fell(diagBusyFlag) && ampStartBit |-> !muteRelease ##1 muteRelease)
        else $error("unmute order wrong");
    result_view_a: assert property ($past(resultSelectBit) |-> loadResultHighBit == '0 && loadResultLowBit == $past(acLoad))
        else $error("ac view wrong");
    short_clear_a: assert property (resultRead && !resultSelectBit && !diagBusyFlag && measShort == '0 |=> shortedLoad == '0)
        else $error("short bits kept");
endmodule // sld_assertions

bind sld_startup_load_diagnostics sld_assertions i_sldChk (.*);

// >>> verif/sld_load_model.sv
module sld_load_model
    import sld_pkg::*;
(
    input wire logic [2*NUM_CH-1:0] loadKind,
    input wire logic [NUM_CH-1:0] batMask,
    input wire logic [NUM_CH-1:0] gndMask,
    input wire logic testOffsetOn,
    output logic [NUM_CH-1:0] measShort,
    output logic [NUM_CH-1:0] measOpen,
    output logic [NUM_CH-1:0] measBooster,
    output logic [NUM_CH-1:0] measShortBat,
    output logic [NUM_CH-1:0] measShortGnd,
    output logic outputOverLimit
);
    // Kind 3 stands for a load below the short threshold
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            measShort[c] = loadKind[2*c+:2] == 2'h3;
            measOpen[c] = loadKind[2*c+:2] == LOAD_OPEN;
            measBooster[c] = loadKind[2*c+:2] == LOAD_LINE;
        end
    end
    assign measShortBat = batMask;
    assign measShortGnd = gndMask;
    // Battery short lifts the output once the test offset is on
    assign outputOverLimit = testOffsetOn && (|batMask);
endmodule // sld_load_model

// >>> verif/testbench.sv
module testbench
    import sld_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [7:0] pins; logic oe;} sld_row_s;
    logic clk, resetn, i2cMode, ampStartBit, diagEnableBit, lowSupplyClipEnableBit;
    logic resultSelectBit, shortReportDisable, ovPrewarnEnable, resultRead, outputOverLimit;
    logic engineStart, supplyLow, ovPrewarn, clipDetect, otherFault, diagBusyFlag;
    logic ampOnStatusBit, lineDriverAllowed, testOffsetOn, testOffsetHigh, muteRelease;
    logic faultPinOe, faultPinOut;
    logic [NUM_CH-1:0] acLoad, measShort, measOpen, measBooster, measShortBat, measShortGnd;
    logic [NUM_CH-1:0] loadResultHighBit, loadResultLowBit, shortedLoad, shortToBat, shortToGnd;
    logic [NUM_CH-1:0] batMask, gndMask;
    logic [2*NUM_CH-1:0] loadKind;
    int mismatches, numChecks;
    // Pins: mode, short hide, ov enable, low clip, low supply, ov, clip, other
    sld_row_s rows [7] = '{'{8'h80, 1'b0}, '{8'h84, 1'b0}, '{8'hA4, 1'b1}, '{8'h24, 1'b0},
        '{8'h02, 1'b1}, '{8'h0A, 1'b0}, '{8'h81, 1'b1}};
    sld_startup_load_diagnostics #(.OFFSET_CYC(10), .WINDOW_CYC(40), .START_CYC(10)) i_dut (.*);
    sld_load_model i_load (.*);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        numChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Index 0 busy, 1 amp on
    task automatic wait_for(input int idx, input logic v);
        int n;
        n = 0;
        while ((idx != 0 ? ampOnStatusBit : diagBusyFlag) !== v && n < 2000) begin
            step(1);
            n++;
        end
        chk("wait", {7'h00, v}, {7'h00, (idx != 0 ? ampOnStatusBit : diagBusyFlag)});
    endtask
    task automatic set_pins(input logic [7:0] p);
        {i2cMode, shortReportDisable, ovPrewarnEnable, lowSupplyClipEnableBit} = p[7:4];
        {supplyLow, ovPrewarn, clipDetect, otherFault} = p[3:0];
    endtask
    task automatic rerun();
        diagEnableBit = 1'b0;
        step(2);
        diagEnableBit = 1'b1;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", numChecks, mismatches);
        if (mismatches == 0 && numChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        complete_run();
    end
    initial begin
        {resetn, ampStartBit, diagEnableBit, resultSelectBit, resultRead, engineStart} = '0;
        {acLoad, batMask, gndMask} = '0;
        set_pins(8'h80);
        loadKind = 8'hE4;
        repeat (12) @(posedge clk);
        #1;
        resetn = 1'b1;
        step(1);
        chk("porPin", 8'h01, faultPinOe);
        chk("pinLevel", 8'h00, faultPinOut);
        chk("porCodes", 8'hFF, {loadResultHighBit, loadResultLowBit});
        diagEnableBit = 1'b1;
        wait_for(0, 1'b1);
        chk("startCodes", 8'hFF, {loadResultHighBit, loadResultLowBit});
        wait_for(0, 1'b0);
        chk("codes", 8'h22, {loadResultHighBit[2:0], loadResultLowBit[2:0]});
        chk("shorted", 8'h08, shortedLoad);
        chk("ampOff", 8'h00, ampOnStatusBit);
        chk("booster", 8'h01, lineDriverAllowed);
        resultSelectBit = 1'b1;
        acLoad = 4'h5;
        step(2);
        chk("acView", 8'h05, {loadResultHighBit, loadResultLowBit});
        resultSelectBit = 1'b0;
        step(2);
        chk("kept", 8'h22, {loadResultHighBit[2:0], loadResultLowBit[2:0]});
        ampStartBit = 1'b1;
        wait_for(1, 1'b1);
        step(2);
        chk("shortPin", 8'h01, faultPinOe);
        set_pins(8'hC0);
        step(2);
        chk("shortHidden", 8'h00, faultPinOe);
        // Filter needs the load stable before the read
        loadKind = 8'h24;
        step(70);
        resultRead = 1'b1;
        step(1);
        resultRead = 1'b0;
        step(1);
        chk("shortRead", 8'h00, shortedLoad);
        foreach (rows[i]) begin
            set_pins(rows[i].pins);
            step(2);
            chk("faultPin", {7'h00, rows[i].oe}, {7'h00, faultPinOe});
        end
        set_pins(8'h80);
        ampStartBit = 1'b0;
        wait_for(1, 1'b0);
        rerun();
        step(2);
        ampStartBit = 1'b1;
        wait_for(0, 1'b1);
        wait_for(0, 1'b0);
        step(1);
        chk("unmute", 8'h01, muteRelease);
        chk("codes2", 8'h42, {loadResultHighBit, loadResultLowBit});
        ampStartBit = 1'b0;
        wait_for(1, 1'b0);
        batMask = 4'h2;
        rerun();
        wait_for(0, 1'b1);
        chk("rerunCodes", 8'hFF, {loadResultHighBit, loadResultLowBit});
        wait_for(0, 1'b0);
        chk("offsetOff", 8'h00, testOffsetOn);
        chk("batCode", 8'h03, {loadResultHighBit[1], loadResultLowBit[1]});
        complete_run();
    end
endmodule // testbench
